/* File: verilog/prs_consts.vh */
// Constants of the palette recipe selector
`ifndef PRS_CONSTS_VH
`define PRS_CONSTS_VH
// ==========================================
// Sizes
`define PRS_SLOTS        10
`define PRS_GROUPS       8
`define PRS_ENTRIES      80
`define PRS_VAL_W        16
`define PRS_IDX_W        7
`define PRS_CH_W         5
`define PRS_PN_W         7
`define PRS_PAL_W        3
// ==========================================
// Reset values
`define PRS_TGT_RST      12'h000
`define PRS_PAL_RST      3'h0
// ==========================================
// Channel codes screened from the slot targets, main, calibration and totaliser only for listed parameters
`define PRS_CH_MAIN      5'h01
`define PRS_CH_PAL       5'h04
`define PRS_CH_MON       5'h07
`define PRS_CH_SET       5'h08
`define PRS_CH_SYS       5'h09
`define PRS_CH_ALM       5'h0a
`define PRS_CH_COM       5'h0b
`define PRS_CH_CAL       5'h0f
`define PRS_CH_TOT       5'h10
`define PRS_CH_LINK      5'h1d
`define PRS_CH_RCP       5'h1e
// ==========================================
// Parameter numbers kept out of the slot targets
`define PRS_PN_STANDBY_SELECT      7'h05
`define PRS_PN_AT        7'h07
`define PRS_PN_HOLD      7'h08
`define PRS_PN_PAL       7'h09
`define PRS_PN_REBOOT    7'h63
`define PRS_PN_TGO       7'h01
`define PRS_PN_TCLR      7'h02
`define PRS_PN_TPRE      7'h12
`define PRS_PN_CAL       7'h08
`endif

/* File: verilog/prs_value_mem.v */
// Stored recipe values, eighty words with registered read data
`timescale 1ns/1ps
module prs_value_mem
(
   // Clock
   input  wire        clk,
   // Write port
   input  wire        wr_en,
   input  wire [6:0]  wr_addr,
   input  wire [15:0] wr_data,
   // Read port
   input  wire [6:0]  rd_addr,
   output reg  [15:0] rd_data
);
   reg [15:0] mem [0:79];

   always @(posedge clk)
   begin
      if (wr_en && wr_addr < 7'd80)
         mem[wr_addr] <= wr_data;
      rd_data <= (rd_addr < 7'd80) ? mem[rd_addr] : 16'h0000;
   end
endmodule

/* File: verilog/prs_palette_recipe_selector.v */
// Palette recipe selector: copies stored values into targeted parameters
// What this block does
// - Palette change overwrites targets with new values
// - Ten slots, each choosing its own target
// - Palette zero applies values zero to nine
// - Palette n applies values from ten times n
// - Slot assignments take effect after reset only
// - Masked parameters are refused as slot targets
// - Applied values clamped to target's legal range
// - Eighty independent stored values, slot by palette
`timescale 1ns/1ps
`include "prs_consts.vh"
module prs_palette_recipe_selector
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst_n,
   // Slot target configuration, written by the parameter store
   input  wire        tgt_wr,
   input  wire [3:0]  tgt_slot,
   input  wire [11:0] recipe_slot_target,
   input  wire        tgt_masked,
   // Stored value table
   input  wire        val_wr,
   input  wire [6:0]  val_idx,
   input  wire [15:0] palette_value_table,
   // Palette logic
   input  wire [2:0]  palette_number,
   // Legal range of the parameter being written
   output reg  [11:0] range_query,
   input  wire [15:0] range_min,
   input  wire [15:0] range_max,
   // Parameter store write port
   output reg         par_wr,
   output reg  [11:0] par_addr,
   output reg  [15:0] par_data,
   // Status
   output wire        busy,
   output wire [9:0]  slot_active,
   output reg         tgt_refused
);
   // ==========================================
   // Slot assignments: pending copy and active copy
   localparam ST_IDLE  = 4'b0001;
   localparam ST_READ  = 4'b0010;
   localparam ST_WAIT  = 4'b0100;
   localparam ST_WRITE = 4'b1000;

   reg  [11:0] pend_tgt [0:9];
   reg  [9:0]  pend_ok = 10'h000;
   reg  [11:0] act_tgt  [0:9];
   reg  [9:0]  act_ok;
   reg         loaded;
   reg  [3:0]  state;
   reg  [3:0]  slot;
   reg  [2:0]  pal_seen;
   reg  [2:0]  pal_run;
   wire [15:0] rd_data;
   wire [4:0]  in_ch = recipe_slot_target[11:7];
   wire [6:0]  in_pn = recipe_slot_target[6:0];
   reg         in_bad;
   reg  [15:0] clamped;
   reg  [6:0]  rd_addr;

   // Target screening
   always @*
   begin
      in_bad = tgt_masked;
      case (in_ch)
         `PRS_CH_PAL, `PRS_CH_MON, `PRS_CH_SET, `PRS_CH_SYS,
         `PRS_CH_ALM, `PRS_CH_COM, `PRS_CH_LINK, `PRS_CH_RCP: in_bad = 1'b1;
         default: in_bad = in_bad;
      endcase
      if ((in_ch == `PRS_CH_MAIN && (in_pn == `PRS_PN_STANDBY_SELECT || in_pn == `PRS_PN_AT ||
           in_pn == `PRS_PN_HOLD || in_pn == `PRS_PN_PAL)) ||
          (in_ch == `PRS_CH_SYS && in_pn == `PRS_PN_REBOOT) ||
          (in_ch == `PRS_CH_TOT && (in_pn == `PRS_PN_TGO || in_pn == `PRS_PN_TCLR ||
           in_pn == `PRS_PN_TPRE)) ||
          (in_ch == `PRS_CH_CAL && in_pn == `PRS_PN_CAL) ||
          recipe_slot_target == `PRS_TGT_RST)
         in_bad = 1'b1;
   end

   // ==========================================
   // Pending assignments, one per slot
   genvar g;
   generate
      for (g = 0; g < `PRS_SLOTS; g = g + 1)
      begin : gen_slot
         // Kept through rst_n like retained settings, cleared at power-up only
         always @(posedge clk)
         begin
            if (tgt_wr && tgt_slot == g && !in_bad)
            begin
               pend_tgt[g] <= recipe_slot_target;
               pend_ok[g]  <= 1'b1;
            end
         end
         // Active copy is captured once after reset release
         always @(posedge clk or negedge rst_n)
         begin
            if (!rst_n)
            begin
               act_tgt[g] <= `PRS_TGT_RST;
               act_ok[g]  <= 1'b0;
            end
            else if (!loaded)
            begin
               act_tgt[g] <= pend_ok[g] ? pend_tgt[g] : `PRS_TGT_RST;
               act_ok[g]  <= pend_ok[g];
            end
         end
      end
   endgenerate

   assign slot_active = act_ok;
   assign busy        = (state != ST_IDLE);

   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         tgt_refused <= 1'b0;
      else
         tgt_refused <= tgt_wr && (in_bad || tgt_slot >= 4'd10);
   end

   // ==========================================
   // Value store
   always @*
   begin
      rd_addr = {pal_run, 3'b000} + {1'b0, pal_run, 1'b0} + {3'b000, slot};
   end

   prs_value_mem u_mem
   (
      .clk     (clk),
      .wr_en   (val_wr),
      .wr_addr (val_idx),
      .wr_data (palette_value_table),
      .rd_addr (rd_addr),
      .rd_data (rd_data)
   );

   always @*
   begin
      if ($signed(rd_data) < $signed(range_min))
         clamped = range_min;
      else if ($signed(rd_data) > $signed(range_max))
         clamped = range_max;
      else
         clamped = rd_data;
   end

   // ==========================================
   // Copy sequencer
   always @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state       <= ST_IDLE;
         slot        <= 4'h0;
         loaded      <= 1'b0;
         pal_seen    <= `PRS_PAL_RST;
         pal_run     <= `PRS_PAL_RST;
         par_wr      <= 1'b0;
         par_addr    <= 12'h000;
         par_data    <= 16'h0000;
         range_query <= 12'h000;
      end
      else
      begin
         par_wr <= 1'b0;
         case (state)
            ST_IDLE:
            begin
               if (!loaded)
               begin
                  loaded   <= 1'b1;
                  pal_seen <= palette_number;
                  pal_run  <= palette_number;
                  slot     <= 4'h0;
                  state    <= ST_READ;
               end
               else if (palette_number != pal_seen)
               begin
                  pal_seen <= palette_number;
                  pal_run  <= palette_number;
                  slot     <= 4'h0;
                  state    <= ST_READ;
               end
            end
            ST_READ:
            begin
               range_query <= act_tgt[slot];
               state       <= ST_WAIT;
            end
            ST_WAIT:
               state <= ST_WRITE;
            ST_WRITE:
            begin
               if (act_ok[slot])
               begin
                  par_wr   <= 1'b1;
                  par_addr <= act_tgt[slot];
                  par_data <= clamped;
               end
               if (slot == 4'd9)
                  state <= ST_IDLE;
               else
               begin
                  slot  <= slot + 4'd1;
                  state <= ST_READ;
               end
            end
            default:
               state <= ST_IDLE;
         endcase
      end
   end
endmodule

/* File: test/prs_store_model.sv */
// Parameter store model answering legal ranges
`timescale 1ns/1ps
module prs_store_model
(
   // Range lookup
   input  wire logic [11:0] range_query,
   output logic      [15:0] range_min,
   output logic      [15:0] range_max
);
   // Range keyed by channel and parameter number
   assign range_min = 16'hff9c;
   assign range_max = 16'h0064 + {4'h0, range_query};
endmodule

/* File: test/prs_chk_asserts.sv */
// Port checker for the recipe selector
`timescale 1ns/1ps
module prs_chk
(
   // Clock and reset
   input wire logic        clk,
   input wire logic        rst_n,
   // Slot target configuration
   input wire logic        tgt_wr,
   input wire logic [3:0]  tgt_slot,
   input wire logic [11:0] recipe_slot_target,
   input wire logic        tgt_masked,
   // Stored value table
   input wire logic        val_wr,
   input wire logic [6:0]  val_idx,
   input wire logic [15:0] palette_value_table,
   // Palette and range lookup
   input wire logic [2:0]  palette_number,
   input wire logic [11:0] range_query,
   input wire logic [15:0] range_min,
   input wire logic [15:0] range_max,
   // Parameter store write port and status
   input wire logic        par_wr,
   input wire logic [11:0] par_addr,
   input wire logic [15:0] par_data,
   input wire logic        busy,
   input wire logic [9:0]  slot_active,
   input wire logic        tgt_refused
);
   default clocking @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========
   // Properties
   wr_pulse_a: assert property (par_wr |=> !par_wr)
      else $error("long par_wr");
   pal_start_a: assert property ($changed(palette_number) && !busy |-> ##[0:2] busy)
      else $error("no copy");
   seq_len_a: assert property ($rose(busy) |-> busy[*8] ##1 busy[*8] ##1 busy[*8] ##1 busy[*6] ##1 !busy)
      else $error("bad copy length");
   hold_target_a: assert property (tgt_wr |=> $stable(slot_active))
      else $error("target early");
   mask_refuse_a: assert property (tgt_wr && tgt_masked |=> tgt_refused)
      else $error("masked kept");
   chan_refuse_a: assert property (tgt_wr && recipe_slot_target[11:7] == 5'h04 |=> tgt_refused)
      else $error("channel kept");
   param_refuse_a: assert property (tgt_wr && recipe_slot_target == 12'h089 |=> tgt_refused)
      else $error("param kept");
   value_clamp_a: assert property (par_wr |->
      $signed(par_data) >= $signed(range_min) && $signed(par_data) <= $signed(range_max))
      else $error("unclamped");
   no_target_a: assert property (par_wr |-> |slot_active)
      else $error("write without target");
   write_addr_a: assert property (par_wr |-> par_addr != 12'h000)
      else $error("write to empty target");
endmodule
bind prs_palette_recipe_selector prs_chk u_chk
(
   .clk                 (clk),
   .rst_n               (rst_n),
   .tgt_wr              (tgt_wr),
   .tgt_slot            (tgt_slot),
   .recipe_slot_target  (recipe_slot_target),
   .tgt_masked          (tgt_masked),
   .val_wr              (val_wr),
   .val_idx             (val_idx),
   .palette_value_table (palette_value_table),
   .palette_number      (palette_number),
   .range_query         (range_query),
   .range_min           (range_min),
   .range_max           (range_max),
   .par_wr              (par_wr),
   .par_addr            (par_addr),
   .par_data            (par_data),
   .busy                (busy),
   .slot_active         (slot_active),
   .tgt_refused         (tgt_refused)
);

/* File: test/tb.sv */
// Testbench for the palette recipe selector
`timescale 1ns/1ps
module tb;
   logic        clk, rst_n, tgt_wr, tgt_masked, val_wr, par_wr, busy, tgt_refused;
   logic [3:0]  tgt_slot;
   logic [11:0] tgt, range_query, par_addr;
   logic [6:0]  val_idx;
   logic [15:0] val, range_min, range_max, par_data;
   logic [2:0]  pal;
   logic [9:0]  slot_active;
   int          fails, n_tests, wr_seen, i;
   logic [27:0] wr_log [8];
   // Rows: expected refusal, masked, target
   logic [13:0] rows [21] = '{14'h008a, 14'h308a, 14'h2000, 14'h2201, 14'h2381, 14'h2401, 14'h2481,
      14'h2501, 14'h2581, 14'h2e81, 14'h2f01, 14'h2085, 14'h2087, 14'h2088, 14'h2089, 14'h24e3,
      14'h2801, 14'h2802, 14'h2812, 14'h2788, 14'h0103};

   prs_palette_recipe_selector u_dut (.clk(clk), .rst_n(rst_n), .tgt_wr(tgt_wr), .tgt_slot(tgt_slot),
      .recipe_slot_target(tgt), .tgt_masked(tgt_masked), .val_wr(val_wr), .val_idx(val_idx),
      .palette_value_table(val), .palette_number(pal), .range_query(range_query),
      .range_min(range_min), .range_max(range_max), .par_wr(par_wr), .par_addr(par_addr),
      .par_data(par_data), .busy(busy), .slot_active(slot_active), .tgt_refused(tgt_refused));
   prs_store_model u_store (.range_query(range_query), .range_min(range_min), .range_max(range_max));

   initial
   begin
      clk = 0;
      forever #25 clk = ~clk;
   end

   // Writes logged at the falling edge, clear of the launching edge
   always @(negedge clk)
      if (par_wr === 1'b1)
      begin
         if (wr_seen < 8)
            wr_log[wr_seen] = {par_addr, par_data};
         wr_seen++;
      end

   task automatic check(input logic ok, input string msg);
      n_tests++;
      if (ok !== 1'b1)
      begin
         fails++;
         $display("CHECK FAILED %0t %s", $time, msg);
      end
   endtask

   task automatic wait_idle;
      for (int k = 0; k < 60 && busy !== 1'b0; k++)
         @(negedge clk);
   endtask

   task automatic set_pal(input logic [2:0] p);
      pal = p;
      repeat (2) @(negedge clk);
      wait_idle;
   endtask

   task automatic wrap_up;
      $display("fails=%0d n_tests=%0d", fails, n_tests);
      if (fails == 0 && n_tests > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   initial
   begin
      #200000;
      fails++;
      $display("CHECK FAILED %0t watchdog", $time);
      wrap_up;
   end

   initial
   begin
      {rst_n, tgt_wr, tgt_masked, val_wr, tgt_slot, tgt, val_idx, val, pal} = '0;
      repeat (3) @(negedge clk);
      rst_n = 1;
      repeat (40) @(negedge clk);
      for (i = 0; i < 21; i++)
      begin
         {tgt_masked, tgt} = rows[i][12:0];
         tgt_slot = 4'(i % 10);
         tgt_wr = 1;
         @(negedge clk);
         check(tgt_refused === rows[i][13], "refusal");
         check(slot_active === 10'h000, "target early");
      end
      // Slot 5 at the widest range, then a slot past the last
      tgt_slot = 4'h5;
      tgt = 12'hfff;
      @(negedge clk);
      check(tgt_refused === 1'b0, "slot 5 refused");
      tgt_slot = 4'hc;
      tgt = 12'h08a;
      @(negedge clk);
      check(tgt_refused === 1'b1, "slot 12 kept");
      tgt_wr = 0;
      // Fill every value, one past the end too
      for (i = 0; i < 81; i++)
      begin
         val_idx = 7'(i);
         val = 16'(i * 257);
         val_wr = 1;
         @(negedge clk);
      end
      // Negative value for palette 2, small one for palette 7
      val_idx = 7'h19;
      val = 16'h8000;
      @(negedge clk);
      val_idx = 7'h4b;
      val = 16'h0abc;
      @(negedge clk);
      val_wr = 0;
      pal = 3;
      repeat (3) @(negedge clk);
      check(busy === 1'b1, "no copy");
      pal = 5;
      wait_idle;
      repeat (3) @(negedge clk);
      check(busy === 1'b1, "late change lost");
      wait_idle;
      check(busy === 1'b0, "copy hangs");
      check(wr_seen == 0, "write without target");
      // Reset in mid-run
      pal = 0;
      repeat (2) @(negedge clk);
      rst_n = 0;
      #1;
      check({busy, par_wr, tgt_refused, slot_active} === 13'h0000, "reset");
      @(negedge clk);
      rst_n = 1;
      repeat (2) @(negedge clk);
      wait_idle;
      check(slot_active === 10'h021, "target after reset");
      check(wr_seen == 2, "writes at palette 0");
      check(wr_log[0] === {12'h103, 16'h0000}, "palette 0 slot 0");
      check(wr_log[1] === {12'hfff, 16'h0505}, "palette 0 slot 5");
      set_pal(3'h1);
      check(wr_log[2] === {12'h103, 16'h0167}, "clamp high");
      check(wr_log[3] === {12'hfff, 16'h0f0f}, "palette 1 slot 5");
      set_pal(3'h2);
      check(wr_log[5] === {12'hfff, 16'hff9c}, "clamp low");
      set_pal(3'h7);
      check(wr_log[7] === {12'hfff, 16'h0abc}, "palette 7 slot 5");
      check(wr_seen == 8 && busy === 1'b0, "write count");
      wrap_up;
   end
endmodule
